// [include/adc_port_pkg.sv]
// Purpose: shared constants and types for the converter control and read port
// Assumes: sys_clk at 20 MHz, all pins synchronous to it
// Notes: timing counts derive from printed times and the clock period
// Function
// - after a rising trigger edge the part leaves power-down and is fully powered within 1.5 us.
// - a rising trigger edge launches an internal wake window lasting 1.5 us.
// - a falling trigger edge starts a conversion only once the wake window is over.
// - busy stays high for the whole conversion, which takes at most 2.3 us; here a full result buffer stretches it beyond that.
// - busy rises no later than 30 ns after the falling edge that starts a conversion; here it rises at the next clock edge, 50 ns later.
// - at the end of each conversion the trigger level is sampled to pick the power mode.
// - the data bus is driven only while chip select and read are both low; here result_bus_oe follows them one cycle late.
// - out of reset the part is powered down and waits for a wake edge.
package adc_port_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WAKE_NS = 1500;
    localparam int CONV_NS = 2300;
    localparam int BUSY_DELAY_NS = 30;
    // longest times round down, never below one cycle
    localparam int WAKE_CYC = (WAKE_NS / CLK_PERIOD_NS < 1) ? 1 : WAKE_NS / CLK_PERIOD_NS;
    localparam int CONV_CYC = (CONV_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_NS / CLK_PERIOD_NS;
    localparam int BUSY_DELAY_CYC =
        (BUSY_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : BUSY_DELAY_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam int CODE_W = 10;
    localparam int BYTE_W = 8;
    localparam int LSB_W = 2;
    localparam int MSB_POS = CODE_W - BYTE_W;
    localparam int BUF_DEPTH = 2;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

    typedef enum logic [3:0] {
        st_down = 4'h1,
        st_wake = 4'h2,
        st_ready = 4'h4,
        st_conv = 4'h8
    } state_t;
endpackage

// [include/result_if.sv]
// Purpose: valid/ready carrier for one conversion code
// Assumes: single clock domain
// Notes: a word moves when valid and ready are both high
`timescale 1ns/10ps
interface result_if;
    logic valid;
    logic ready;
    logic [adc_port_pkg::CODE_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [rtl/result_buffer.sv]
// Purpose: two-entry buffer between converter and read port
// Assumes: single clock, asynchronous active-high reset
// Notes: ready on the fill side drops when both entries hold data
`timescale 1ns/10ps
module result_buffer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    result_if.snk fill,
    result_if.src drain
);
    logic [adc_port_pkg::CODE_W-1:0] mem_r [adc_port_pkg::BUF_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    logic push;
    logic pop;

    assign fill.ready = (count_r != 2'h2);
    assign drain.valid = (count_r != 2'h0);
    assign drain.data = mem_r[rd_ptr_r];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < adc_port_pkg::BUF_DEPTH; i++) begin : g_entry
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                mem_r[i] <= 10'h000;
            end else if (push && (wr_ptr_r == 1'(i))) begin
                mem_r[i] <= fill.data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= 1'h0;
            rd_ptr_r <= 1'h0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end

    a_buf_no_overfill: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count_r <= 2'h2)
        else $error("buffer count above two");
endmodule // result_buffer

// [rtl/adc_port.sv]
// Purpose: conversion control, power sequencing and two-byte parallel read port
// Assumes: pins synchronous to sys_clk; conv_code is the core's settled code
// Notes: data bus is registered, so it follows the strobes one cycle late
`timescale 1ns/10ps
module adc_port (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic conversion_trigger_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [adc_port_pkg::CODE_W-1:0] conv_code,
    output logic busy,
    output logic powered,
    output logic [adc_port_pkg::BYTE_W-1:0] result_bus,
    output logic result_bus_oe
);
    adc_port_pkg::state_t state_r;
    logic trig_prev_r;
    logic start_pend_r;
    logic [adc_port_pkg::CNT_W-1:0] cnt_r;
    logic busy_r;
    logic powered_r;
    logic byte_sel_r;
    logic [adc_port_pkg::BYTE_W-1:0] bus_r;
    logic oe_r;
    logic trig_rise;
    logic trig_fall;
    logic conv_end;
    logic read_on;
    logic read_end;
    logic [adc_port_pkg::CODE_W-1:0] head;
    logic [adc_port_pkg::CNT_W-1:0] run_len_r;

    result_if fill_if ();
    result_if drain_if ();

    result_buffer u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    assign trig_rise = conversion_trigger_n && !trig_prev_r;
    assign trig_fall = !conversion_trigger_n && trig_prev_r;
    // a full buffer stretches the conversion rather than dropping a word
    assign conv_end = (state_r == adc_port_pkg::st_conv)
        && (cnt_r == adc_port_pkg::CONV_LAST) && fill_if.ready;
    assign fill_if.valid = conv_end;
    assign fill_if.data = conv_code;
    assign read_on = !cs_n && !rd_n;
    assign read_end = oe_r && !read_on;
    assign drain_if.ready = read_end && byte_sel_r;
    // empty buffer reads as zero, never as a stale word
    assign head = drain_if.valid ? drain_if.data : 10'h000;

    assign busy = busy_r;
    assign powered = powered_r;
    assign result_bus = bus_r;
    assign result_bus_oe = oe_r;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_prev_r <= 1'h1;
        end else begin
            trig_prev_r <= conversion_trigger_n;
        end
    end

    // power and conversion sequencing
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= adc_port_pkg::st_down;
            cnt_r <= adc_port_pkg::CNT_RESET;
            start_pend_r <= 1'h0;
        end else begin
            unique case (state_r)
                adc_port_pkg::st_down: begin
                    if (trig_rise) begin
                        state_r <= adc_port_pkg::st_wake;
                        cnt_r <= adc_port_pkg::CNT_RESET;
                        start_pend_r <= 1'h0;
                    end
                end
                adc_port_pkg::st_wake: begin
                    if (trig_fall) begin
                        start_pend_r <= 1'h1;
                    end else if (trig_rise) begin
                        start_pend_r <= 1'h0;
                    end
                    if (cnt_r == adc_port_pkg::WAKE_LAST) begin
                        cnt_r <= adc_port_pkg::CNT_RESET;
                        // a fall seen in the window starts once it closes, if the trigger is still low then
                        if ((start_pend_r || trig_fall) && !conversion_trigger_n) begin
                            state_r <= adc_port_pkg::st_conv;
                        end else begin
                            state_r <= adc_port_pkg::st_ready;
                        end
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                adc_port_pkg::st_ready: begin
                    cnt_r <= adc_port_pkg::CNT_RESET;
                    start_pend_r <= 1'h0;
                    if (trig_fall) begin
                        state_r <= adc_port_pkg::st_conv;
                    end else if (trig_rise) begin
                        state_r <= adc_port_pkg::st_wake;
                    end
                end
                adc_port_pkg::st_conv: begin
                    start_pend_r <= 1'h0;
                    if (conv_end) begin
                        cnt_r <= adc_port_pkg::CNT_RESET;
                        if (conversion_trigger_n) begin
                            state_r <= adc_port_pkg::st_ready;
                        end else begin
                            state_r <= adc_port_pkg::st_down;
                        end
                    end else if (cnt_r != adc_port_pkg::CONV_LAST) begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                default: begin
                    state_r <= adc_port_pkg::st_down;
                    cnt_r <= adc_port_pkg::CNT_RESET;
                    start_pend_r <= 1'h0;
                end
            endcase
        end
    end

    // busy and power flags registered alongside the state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'h0;
            powered_r <= 1'h0;
        end else begin
            busy_r <= 1'h0;
            powered_r <= (state_r != adc_port_pkg::st_down);
            if (state_r == adc_port_pkg::st_conv) begin
                busy_r <= !conv_end;
                powered_r <= conv_end ? conversion_trigger_n : 1'h1;
            end else if (state_r == adc_port_pkg::st_ready && trig_fall) begin
                busy_r <= 1'h1;
            end else if (state_r == adc_port_pkg::st_wake
                && cnt_r == adc_port_pkg::WAKE_LAST) begin
                busy_r <= (start_pend_r || trig_fall) && !conversion_trigger_n;
            end else if (state_r == adc_port_pkg::st_down) begin
                powered_r <= trig_rise;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port; byte order relies on the host strobing upper then lower
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_r <= 1'h0;
            bus_r <= 8'h00;
        end else begin
            oe_r <= read_on;
            if (byte_sel_r) begin
                bus_r <= {{(adc_port_pkg::BYTE_W - adc_port_pkg::LSB_W){1'h0}},
                    head[adc_port_pkg::LSB_W-1:0]};
            end else begin
                bus_r <= head[adc_port_pkg::CODE_W-1:adc_port_pkg::MSB_POS];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_sel_r <= 1'h0;
        end else if (read_end) begin
            byte_sel_r <= ~byte_sel_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_start_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == adc_port_pkg::st_ready && trig_fall) |=> busy_r)
        else $error("busy late after start edge");

    a_window_blocks: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == adc_port_pkg::st_wake && cnt_r != adc_port_pkg::WAKE_LAST) |=> !busy_r)
        else $error("conversion began inside wake window");

    a_wake_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == adc_port_pkg::st_down && trig_rise)
        |=> (state_r == adc_port_pkg::st_wake) ##30 (state_r != adc_port_pkg::st_wake))
        else $error("wake window not thirty cycles");

    a_busy_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(busy_r) |-> busy_r [*8])
        else $error("busy dropped early");

    // helper: unstalled busy cycles in a row, saturating
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_len_r <= adc_port_pkg::CNT_RESET;
        end else if (busy_r && fill_if.ready) begin
            if (run_len_r != 6'h3F) begin
                run_len_r <= run_len_r + 6'h01;
            end
        end else begin
            run_len_r <= adc_port_pkg::CNT_RESET;
        end
    end

    a_conv_bound: assert property (@(posedge sys_clk) disable iff (sys_rst)
        run_len_r <= adc_port_pkg::CNT_W'(adc_port_pkg::CONV_CYC))
        else $error("conversion longer than limit");

    a_auto_down: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (conv_end && !conversion_trigger_n) |=> (state_r == adc_port_pkg::st_down) && !powered_r)
        else $error("no power-down after low trigger");

    a_stay_up: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (conv_end && conversion_trigger_n) |=> (state_r == adc_port_pkg::st_ready) && powered_r)
        else $error("powered down after high trigger");

    a_bus_hiz: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(!cs_n && !rd_n) |=> !result_bus_oe)
        else $error("bus driven without select and read");

    a_bus_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!cs_n && !rd_n) |=> result_bus_oe)
        else $error("bus not driven during read");

    a_upper_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (read_on && !byte_sel_r) |=> (result_bus == $past(head[9:2])))
        else $error("first read not upper byte");

    a_reset_down: assert property (@(posedge sys_clk)
        $fell(sys_rst) |-> (state_r == adc_port_pkg::st_down) && !powered_r)
        else $error("not powered down after reset");

    c_wake_conv: cover property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == adc_port_pkg::st_wake) ##1 busy_r);
    c_fast_conv: cover property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == adc_port_pkg::st_ready && trig_fall));
    c_two_reads: cover property (@(posedge sys_clk) disable iff (sys_rst)
        drain_if.ready && drain_if.valid);
    c_stall: cover property (@(posedge sys_clk) disable iff (sys_rst)
        busy_r && !fill_if.ready);
endmodule // adc_port

// [dv/host_model.sv]
// Purpose: host side of the trigger pin and the parallel read port
// Assumes: all host pins move just after a rising edge of sys_clk
// Notes: a released bus reads as a pattern that flips each cycle, so old data returns on every second cycle
`timescale 1ns/10ps
module host_model (
    input wire logic sys_clk,
    input wire logic [7:0] result_bus,
    input wire logic result_bus_oe,
    output logic conversion_trigger_n,
    output logic cs_n,
    output logic rd_n
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] bus_seen;
    // no pull-up on the bus, so a floating bus flips each cycle
    assign bus_seen = result_bus_oe ? result_bus : ~last_r;
    always_ff @(posedge sys_clk) last_r <= bus_seen;
    initial begin
        conversion_trigger_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic pin(input logic v);
        @(posedge sys_clk);
        conversion_trigger_n <= v;
    endtask
    // oe_seen: select only, strobe held, after release
    task automatic read_byte(input logic use_cs, output logic [7:0] d,
                             output logic [2:0] oe_seen);
        @(posedge sys_clk);
        cs_n <= !use_cs;
        @(posedge sys_clk);
        rd_n <= 1'b0;
        #1;
        oe_seen[2] = result_bus_oe;
        @(posedge sys_clk);
        #1;
        oe_seen[1] = result_bus_oe;
        d = bus_seen;
        @(posedge sys_clk);
        rd_n <= 1'b1;
        @(posedge sys_clk);
        cs_n <= 1'b1;
        #1;
        oe_seen[0] = result_bus_oe;
        // three idle cycles before the caller's next strobe
    endtask
endmodule // host_model

// [dv/tb.sv]
// Purpose: self-checking bench for the converter control and read port
// Assumes: 20 MHz clock, host model drives the pins
// Notes: the buffer is filled until a conversion stalls, then drained
`timescale 1ns/10ps
module tb;
    localparam int WAKE = adc_port_pkg::WAKE_CYC;
    localparam int CONV = adc_port_pkg::CONV_CYC;
    logic sys_clk, sys_rst, busy, powered, result_bus_oe;
    logic conversion_trigger_n, cs_n, rd_n;
    logic [9:0] conv_code;
    logic [7:0] result_bus;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    adc_port adc_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .conversion_trigger_n(conversion_trigger_n), .cs_n(cs_n), .rd_n(rd_n),
        .conv_code(conv_code), .busy(busy), .powered(powered),
        .result_bus(result_bus), .result_bus_oe(result_bus_oe));
    host_model host_model_inst (.sys_clk(sys_clk), .result_bus(result_bus),
        .result_bus_oe(result_bus_oe), .conversion_trigger_n(conversion_trigger_n),
        .cs_n(cs_n), .rd_n(rd_n));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // a hang costs one mismatch and ends the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            failures++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic start(input logic [9:0] code, output int n);
        @(posedge sys_clk);
        conv_code <= code;
        host_model_inst.pin(1'b0);
        n = 0;
        while (busy !== 1'b1 && n < WAKE + 4) begin
            ticks(1);
            n++;
        end
    endtask
    // busy falling marks the end of conversion
    task automatic busy_len(output int n);
        n = 0;
        while (busy === 1'b1 && n < 200) begin
            ticks(1);
            n++;
        end
    endtask
    task automatic read_word(input logic [9:0] code);
        logic [7:0] d;
        logic [2:0] oe;
        host_model_inst.read_byte(1'b1, d, oe);
        chk(d, code[9:2]);
        chk({5'h00, oe}, 8'h02);
        host_model_inst.read_byte(1'b1, d, oe);
        chk(d, {6'h00, code[1:0]});
        chk({5'h00, oe}, 8'h02);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(busy, 8'h00);
        chk(powered, 8'h00);
        chk(result_bus_oe, 8'h00);
        host_model_inst.pin(1'b0);
        ticks(5);
        chk(busy, 8'h00);
        chk(powered, 8'h00);
    endtask
    task automatic t_window();
        int n;
        host_model_inst.pin(1'b1);
        ticks(2);
        chk(powered, 8'h01);
        ticks(3);
        start(10'h2C9, n);
        chkn(n >= 15 && n <= WAKE, 1);
        busy_len(n);
        chkn(n, CONV);
        ticks(1);
        chk(powered, 8'h00);
    endtask
    task automatic t_reads();
        logic [7:0] d;
        logic [2:0] oe;
        // strobe without select must leave the bus released
        host_model_inst.read_byte(1'b0, d, oe);
        chk({5'h00, oe}, 8'h00);
        read_word(10'h2C9);
    endtask
    task automatic t_fast();
        int n;
        host_model_inst.pin(1'b1);
        ticks(WAKE + 2);
        start(10'h155, n);
        chkn(n, 1);
        host_model_inst.pin(1'b1);
        busy_len(n);
        ticks(1);
        chk(powered, 8'h01);
        ticks(2);
        start(10'h3FF, n);
        chk(busy, 8'h01);
        busy_len(n);
        ticks(1);
        chk(powered, 8'h00);
    endtask
    task automatic t_stall();
        int n;
        host_model_inst.pin(1'b1);
        ticks(WAKE + 2);
        start(10'h0A6, n);
        ticks(CONV + 10);
        // two unread words: this conversion must hold, not drop its code
        chk(busy, 8'h01);
        read_word(10'h155);
        busy_len(n);
        chkn(n <= 6, 1);
        ticks(1);
        chk(powered, 8'h00);
        read_word(10'h3FF);
        read_word(10'h0A6);
        read_word(10'h000);
    endtask
    // reset in mid-conversion must drop busy and power at once
    task automatic t_rerun();
        int n;
        host_model_inst.pin(1'b1);
        ticks(WAKE + 2);
        start(10'h1E3, n);
        ticks(5);
        chk(busy, 8'h01);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        ticks(1);
        chk(busy, 8'h00);
        chk(powered, 8'h00);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        ticks(2);
        chk(busy, 8'h00);
        chk(powered, 8'h00);
        host_model_inst.pin(1'b1);
        ticks(2);
        chk(powered, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        conv_code = 10'h000;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        ticks(1);
        t_reset();
        t_window();
        t_reads();
        t_fast();
        t_stall();
        t_rerun();
        stop_test();
    end
endmodule // tb
